// File: inc/i2rs_regs.vh
// Constants for the two-wire register access target
`ifndef I2RS_REGS_VH
`define I2RS_REGS_VH

// Address pointer and register data widths
`define I2RS_PTR_W      16
`define I2RS_DATA_W     8
// Target address width and four selectable base addresses
`define I2RS_TADDR_W    7
`define I2RS_TADDR_0    7'h48
`define I2RS_TADDR_1    7'h49
`define I2RS_TADDR_2    7'h4a
`define I2RS_TADDR_3    7'h4b
// Bit count of one byte, acknowledge slot is the next one
`define I2RS_BYTE_BITS  4'h8
// Fastest serial clock supported, in kHz
`define I2RS_FAST_KHZ   400
`define I2RS_STD_KHZ    100
// Reset value of the address pointer
`define I2RS_PTR_RST    16'h0000

`endif

// File: src/i2rs_sync.v
// Two-flop synchroniser with edge flags for the serial lines
`timescale 1ns/1ps
module i2rs_sync (
  // Clock and reset
  input  wire mclk_i,
  input  wire nrst_i,
  // Raw pin level
  input  wire pin_i,
  // Synchronised level and edges
  output reg  lvl_o,
  output wire rise_o,
  output wire fall_o
);

  reg meta_q;
  reg prev_q;

  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      meta_q <= 1'b1;
      lvl_o  <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= pin_i;
      lvl_o  <= meta_q;
      prev_q <= lvl_o;
    end
  end

  assign rise_o = lvl_o & ~prev_q;
  assign fall_o = ~lvl_o & prev_q;

endmodule

// File: src/i2rs_target.v
// Two-wire target port giving an outside controller access to the registers
`timescale 1ns/1ps
`include "i2rs_regs.vh"

module i2rs_target #(
  parameter PTR_W  = `I2RS_PTR_W,
  parameter DATA_W = `I2RS_DATA_W
) (
  // Clock and reset
  input  wire              mclk_i,
  input  wire              nrst_i,
  // Serial pins; clock line is input only
  input  wire              scl_i,
  input  wire              sda_i,
  output wire              sda_o,
  output wire              sda_oe_o,
  // Target address select straps
  input  wire [1:0]        addr_sel_i,
  // Register buffer write port
  output reg               wr_stb_o,
  output reg  [PTR_W-1:0]  wr_addr_o,
  output reg  [DATA_W-1:0] wr_data_o,
  // Register read port, data valid the cycle after the address changes
  output wire [PTR_W-1:0]  rd_addr_o,
  input  wire [DATA_W-1:0] rd_data_i,
  // Update request: buffer to active copy
  input  wire              update_pin_i,
  output reg               update_o,
  // Status
  output wire              busy_o
);

  // Protocol states, one-hot:
  // idle waits for a start and ignores everything else,
  // address byte, pointer high byte, pointer low byte,
  // write data bytes, read data bytes,
  // and the shared ninth-bit slot; nxt_q says where it leads.
  // A start or stop overrides every state in the same cycle,
  // so a cut byte never reaches the pointer or the write port.
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_PHI  = 7'h04;
  localparam [6:0] ST_PLO  = 7'h08;
  localparam [6:0] ST_WDAT = 7'h10;
  localparam [6:0] ST_RDAT = 7'h20;
  localparam [6:0] ST_ACK  = 7'h40;

  wire scl_s;
  wire scl_rise;
  wire scl_fall;
  wire sda_s;
  wire sda_rise;
  wire sda_fall;
  wire upd_s;

  reg [6:0]        st_q;
  reg [6:0]        nxt_q;
  reg [3:0]        bit_q;
  reg [7:0]        sh_q;
  reg [PTR_W-1:0]  ptr_q;
  reg              drv_q;
  reg              rd_q;
  reg              upd_prev_q;
  reg [6:0]        taddr_q;
  reg [1:0]        sel_meta_q;
  reg [1:0]        sel_sync_q;
  reg [PTR_W-1:0]  ptr_d;

  // only the data line has an output
  i2rs_sync u_scl (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .pin_i  (scl_i),
    .lvl_o  (scl_s),
    .rise_o (scl_rise),
    .fall_o (scl_fall)
  );

  i2rs_sync u_sda (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .pin_i  (sda_i),
    .lvl_o  (sda_s),
    .rise_o (sda_rise),
    .fall_o (sda_fall)
  );

  i2rs_sync u_upd (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .pin_i  (update_pin_i),
    .lvl_o  (upd_s),
    .rise_o (),
    .fall_o ()
  );

  function [6:0] sel_addr;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    sel_addr = `I2RS_TADDR_0;
        2'h1:    sel_addr = `I2RS_TADDR_1;
        2'h2:    sel_addr = `I2RS_TADDR_2;
        default: sel_addr = `I2RS_TADDR_3;
      endcase
    end
  endfunction

  // Pointer step; wraps at the top so long bursts roll over to zero
  function [PTR_W-1:0] inc_ptr;
    input [PTR_W-1:0] p;
    begin
      inc_ptr = p + {{(PTR_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // True once all eight bits of a byte have been clocked
  function last_bit;
    input [3:0] cnt;
    begin
      last_bit = (cnt == `I2RS_BYTE_BITS);
    end
  endfunction

  // Straps are pins too, so they pass two flops and a registered decode before the compare
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      sel_meta_q <= 2'h0;
      sel_sync_q <= 2'h0;
      taddr_q    <= 7'h00;
    end else begin
      sel_meta_q <= addr_sel_i;
      sel_sync_q <= sel_meta_q;
      // A strap moved in mid-frame is not guarded against
      taddr_q    <= sel_addr(sel_sync_q);
    end
  end

  // One-cycle update pulse on the pin's rising level.
  // The synchroniser resets high, so the previous level does too;
  // otherwise release of reset would fake an update.
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      upd_prev_q <= 1'b1;
      update_o   <= 1'b0;
    end else begin
      upd_prev_q <= upd_s;
      update_o   <= upd_s & ~upd_prev_q;
    end
  end

  // sampled at 250 MHz, far above a 400 kHz bus
  wire start_det = sda_fall & scl_s;
  wire stop_det  = sda_rise & scl_s;

  // Framing events win over bit events in the same cycle
  wire in_frame  = ~start_det & ~stop_det;
  wire byte_end  = in_frame & scl_fall & last_bit(bit_q);
  wire wr_go     = byte_end & (st_q == ST_WDAT);

  assign sda_o     = 1'b0;
  assign sda_oe_o  = drv_q;
  assign rd_addr_o = ptr_q;
  assign busy_o    = (st_q != ST_IDLE);

  // Pointer next value; loads come from the two address bytes
  always @* begin
    ptr_d = ptr_q;
    if (byte_end) begin
      case (st_q)
        ST_PHI: begin
          ptr_d[PTR_W-1:8] = sh_q[PTR_W-9:0];
        end
        ST_PLO: begin
          // Loading alone changes no register
          ptr_d[7:0] = sh_q;
        end
        ST_WDAT, ST_RDAT: begin
          ptr_d = inc_ptr(ptr_q);
        end
        default: begin
          ptr_d = ptr_q;
        end
      endcase
    end
  end

  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      ptr_q <= `I2RS_PTR_RST;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // Buffer write port; address and data stand until the next strobe
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      wr_stb_o  <= 1'b0;
      wr_addr_o <= `I2RS_PTR_RST;
      wr_data_o <= {DATA_W{1'b0}};
    end else begin
      wr_stb_o <= wr_go;
      if (wr_go) begin
        wr_addr_o <= ptr_q;
        wr_data_o <= sh_q;
      end
    end
  end

  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      st_q       <= ST_IDLE;
      nxt_q      <= ST_IDLE;
      bit_q      <= 4'h0;
      sh_q       <= 8'h00;
      drv_q      <= 1'b0;
      rd_q       <= 1'b0;
    end else begin
      if (start_det) begin
        // Partial byte dropped, repeated start accepted
        st_q  <= ST_ADDR;
        bit_q <= 4'h0;
        drv_q <= 1'b0;
      end else if (stop_det) begin
        st_q  <= ST_IDLE;
        drv_q <= 1'b0;
      end else begin
        case (st_q)
          ST_IDLE: begin
            drv_q <= 1'b0;
          end
          ST_ADDR, ST_PHI, ST_PLO, ST_WDAT: begin
            // Bits taken on rising clock, MSB first
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda_s};
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && last_bit(bit_q)) begin
              bit_q <= 4'h0;
              st_q  <= ST_ACK;
              drv_q <= 1'b1;
              case (st_q)
                ST_ADDR: begin
                  if (sh_q[7:1] == taddr_q) begin
                    rd_q  <= sh_q[0];
                    nxt_q <= sh_q[0] ? ST_RDAT : ST_PHI;
                  end else begin
                    // Not addressed: no acknowledge, stay idle
                    st_q  <= ST_IDLE;
                    drv_q <= 1'b0;
                  end
                end
                ST_PHI: begin
                  nxt_q <= ST_PLO;
                end
                ST_PLO: begin
                  nxt_q <= ST_WDAT;
                end
                default: begin
                  // Store and pointer step run in their own processes
                  nxt_q <= ST_WDAT;
                end
              endcase
            end
          end
          ST_RDAT: begin
            // Drive the bit on falling clock; released line reads high
            if (scl_fall) begin
              if (last_bit(bit_q)) begin
                bit_q <= 4'h0;
                drv_q <= 1'b0;
                st_q  <= ST_ACK;
                nxt_q <= ST_RDAT;
              end else begin
                drv_q <= ~sh_q[7];
                sh_q  <= {sh_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          ST_ACK: begin
            if (scl_rise && rd_q && nxt_q == ST_RDAT && sda_s) begin
              // Controller refused the byte: release and idle
              st_q <= ST_IDLE;
            end else if (scl_fall) begin
              drv_q <= 1'b0;
              st_q  <= nxt_q;
              if (nxt_q == ST_RDAT) begin
                // First bit goes out on this same falling edge
                drv_q <= ~rd_data_i[7];
                sh_q  <= {rd_data_i[6:0], 1'b0};
                bit_q <= 4'h1;
              end
            end
          end
          default: begin
            st_q  <= ST_IDLE;
            drv_q <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// File: testbench/i2rs_props.sv
// Port checks for the two-wire target
`timescale 1ns/1ps
module i2rs_props #(
  parameter PTR_W = 16
) (
  // Clock, serial and register side
  input wire             mclk_i,
  input wire             nrst_i,
  input wire             scl_i,
  input wire             sda_i,
  input wire             sda_o,
  input wire             sda_oe_o,
  input wire             wr_stb_o,
  input wire [PTR_W-1:0] wr_addr_o,
  input wire [PTR_W-1:0] rd_addr_o,
  input wire             update_pin_i,
  input wire             update_o,
  input wire             busy_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  drain_only_a: assert property (sda_o == 1'b0) else $error("pin driven high");
  hold_high_a: assert property (scl_i && $past(scl_i, 3) |-> $stable(sda_oe_o))
    else $error("data moved in clock high");
  stb_pulse_a: assert property (wr_stb_o |=> !wr_stb_o) else $error("long strobe");
  ptr_step_a: assert property ($rose(wr_stb_o) |-> ##[0:4] rd_addr_o == wr_addr_o + 1'b1)
    else $error("pointer did not step");
  upd_pulse_a: assert property (update_o |=> !update_o) else $error("long update");
  upd_cause_a: assert property ($rose(update_pin_i) |-> ##[2:8] update_o)
    else $error("update missing");
  stop_idle_a: assert property (scl_i && $rose(sda_i) |-> ##[1:6] !busy_o)
    else $error("busy after stop");
  drive_busy_a: assert property (sda_oe_o |-> busy_o) else $error("drive while idle");
  stb_low_a: assert property (wr_stb_o |-> !scl_i) else $error("strobe in clock high");
  cover property (wr_stb_o);
  cover property (update_o);
  cover property (sda_oe_o && scl_i);
endmodule

// File: testbench/i2rs_ctl.sv
// Behavioural bus controller, open-drain data
`timescale 1ns/1ps
module i2rs_ctl (
  // Clock and bus
  input  wire  mclk_i,
  input  wire  sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // Clock stands high, data released between frames
  initial {scl_o, sda_oe_o} = 2'b10;
  // One quarter of the 64 ns bus period
  task s(input logic c, input logic o);
    scl_o <= c;
    sda_oe_o <= o;
    repeat (4) @(posedge mclk_i);
  endtask
  task bitx(input logic b, output logic r);
    s(1'b0, !b);
    s(1'b1, !b);
    r = sda_i;
    s(1'b1, !b);
    s(1'b0, !b);
  endtask
  task start;
    s(1'b0, 1'b0);
    s(1'b1, 1'b0);
    s(1'b1, 1'b1);
    s(1'b0, 1'b1);
  endtask
  task stop;
    s(1'b0, 1'b1);
    s(1'b1, 1'b1);
    s(1'b1, 1'b0);
  endtask
  // Slot nine carries k; 1 leaves the line high
  task xfer(input logic [7:0] d, input logic k, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(k, a);
  endtask
endmodule

// File: testbench/tb.sv
// Self-checking bench for the two-wire register target
`timescale 1ns/1ps
`include "i2rs_regs.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb;
  logic        mclk_i = 1'b0, nrst_i = 1'b0, update_pin_i = 1'b0;
  logic [1:0]  addr_sel_i = 2'h0;
  logic [31:0] rnd = 32'h0001_1c89;
  logic [23:0] e;
  logic [7:0]  mem [256];
  logic [23:0] exp_q [$];
  int          n_errors = 0, total_checks = 0, n_upd = 0;
  wire         scl_i, c_oe, sda_o, sda_oe_o, wr_stb_o, update_o, busy_o;
  wire [15:0]  wr_addr_o, rd_addr_o;
  wire [7:0]   wr_data_o;
  wire [7:0]   rd_data_i = mem[rd_addr_o[7:0]];
  wire         sda_i = !c_oe && (sda_oe_o === 1'b1 ? sda_o : 1'b1);
  always #2 mclk_i = ~mclk_i;
  i2rs_ctl ctl_u (.mclk_i(mclk_i), .sda_i(sda_i), .scl_o(scl_i), .sda_oe_o(c_oe));
  i2rs_target dut_u (
    .mclk_i       (mclk_i),
    .nrst_i       (nrst_i),
    .scl_i        (scl_i),
    .sda_i        (sda_i),
    .sda_o        (sda_o),
    .sda_oe_o     (sda_oe_o),
    .addr_sel_i   (addr_sel_i),
    .wr_stb_o     (wr_stb_o),
    .wr_addr_o    (wr_addr_o),
    .wr_data_o    (wr_data_o),
    .rd_addr_o    (rd_addr_o),
    .rd_data_i    (rd_data_i),
    .update_pin_i (update_pin_i),
    .update_o     (update_o),
    .busy_o       (busy_o)
  );
  // Register file stand-in; each strobe takes the oldest note
  always @(posedge mclk_i) begin
    if (wr_stb_o) begin
      mem[wr_addr_o[7:0]] <= wr_data_o;
      e = exp_q.size() ? exp_q.pop_front() : 24'hx;
      `CHK({wr_addr_o, wr_data_o}, e)
    end
    if (update_o) n_upd++;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] ta(input logic [1:0] s, input logic rw);
    return {`I2RS_TADDR_0 + {5'h0, s}, rw};
  endfunction
  task automatic wb(input logic [7:0] d, input logic na);
    logic [7:0] q;
    logic       a;
    ctl_u.xfer(d, 1'b1, q, a);
    `CHK(a, na)
  endtask
  task automatic ptr(input logic [15:0] p);
    ctl_u.start;
    wb(ta(addr_sel_i, 1'b0), 1'b0);
    wb(p[15:8], 1'b0);
    wb(p[7:0], 1'b0);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    logic [15:0] p;
    logic [7:0]  d [3];
    logic [7:0]  q;
    logic        a;
    repeat (5) @(posedge mclk_i);
    nrst_i <= 1'b1;
    rnd = lfsr(rnd);
    addr_sel_i <= rnd[1:0];
    p = rnd[23:8];
    repeat (4) @(posedge mclk_i);
    ptr(p);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      d[i] = rnd[7:0];
      exp_q.push_back({p + 16'(i), d[i]});
      wb(d[i], 1'b0);
    end
    ctl_u.stop;
    $display("write burst done");
    ptr(p);
    ctl_u.start;
    wb(ta(addr_sel_i, 1'b1), 1'b0);
    for (int i = 0; i < 3; i++) begin
      ctl_u.xfer(8'hff, i == 2, q, a);
      `CHK(q, d[i])
    end
    ctl_u.stop;
    repeat (8) @(posedge mclk_i);
    `CHK(busy_o, 1'b0)
    `CHK(rd_addr_o, p + 16'h3)
    $display("combined read done");
    ptr(p + 16'h1);
    ctl_u.stop;
    ctl_u.start;
    wb(ta(addr_sel_i, 1'b1), 1'b0);
    ctl_u.xfer(8'hff, 1'b1, q, a);
    `CHK(q, d[1])
    ctl_u.stop;
    $display("split read done");
    ctl_u.start;
    wb(ta(addr_sel_i + 2'h1, 1'b0), 1'b1);
    wb(8'h00, 1'b1);
    ptr(~p);
    for (int i = 0; i < 4; i++) ctl_u.bitx(1'b0, a);
    ptr(~p);
    exp_q.push_back({~p, d[1]});
    wb(d[1], 1'b0);
    ctl_u.stop;
    repeat (8) @(posedge mclk_i);
    `CHK(busy_o, 1'b0)
    $display("miss and abort done");
    for (int i = 0; i < 3; i++) begin
      update_pin_i <= 1'b1;
      repeat (8) @(posedge mclk_i);
      update_pin_i <= 1'b0;
      repeat (8) @(posedge mclk_i);
    end
    `CHK(n_upd, 3)
    $display("update done");
    print_verdict;
  end
  // Tests need about 17 us
  initial begin
    #100000;
    n_errors++;
    print_verdict;
  end
endmodule
bind i2rs_target i2rs_props #(.PTR_W(PTR_W)) chk_u (.*);
